/* gp_timer_pkg.sv */
// Constants shared by the sixteen-bit timer design.
package gp_timer_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] COUNT_OFFSET  = 4'h4;
  localparam logic [3:0] PERIOD_OFFSET = 4'h8;
  localparam logic [3:0] STATUS_OFFSET = 4'hc;

  // ----------------------------------------
  // Control field and status flag positions
  // ----------------------------------------
  localparam int RUN_BIT      = 15;
  localparam int IDLE_BIT     = 13;
  localparam int GATE_BIT     = 6;
  localparam int DIV_LSB      = 4;
  localparam int SYNC_BIT     = 2;
  localparam int SRC_BIT      = 1;
  localparam int MATCH_BIT    = 0;
  localparam int GFALL_BIT    = 1;

  // Writable control bits; the rest read as zero.
  localparam logic [15:0] CTRL_MASK = 16'ha076;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam logic [1:0] CYCLE_DIV_LAST = 2'h3;  // Instruction cycle is four clocks.
  localparam logic [7:0] DIV1_LAST      = 8'h00;
  localparam logic [7:0] DIV8_LAST      = 8'h07;
  localparam logic [7:0] DIV64_LAST     = 8'h3f;
  localparam logic [7:0] DIV256_LAST    = 8'hff;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* input_prescaler.sv */
// Input prescaler dividing counting ticks by 1, 8, 64 or 256.
`timescale 1ns/1ps
module input_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [1:0] input_divide_select,
  output logic            tick_out
);

  logic [7:0] div_count;
  logic [7:0] last_value;
  wire        at_last = (div_count == last_value);

  // Selects the terminal count for the chosen ratio.
  always_comb begin
    unique case (input_divide_select)
      2'h0: last_value = gp_timer_pkg::DIV1_LAST;
      2'h1: last_value = gp_timer_pkg::DIV8_LAST;
      2'h2: last_value = gp_timer_pkg::DIV64_LAST;
      2'h3: last_value = gp_timer_pkg::DIV256_LAST;
    endcase
  end

  assign tick_out = tick_in & at_last;

  // Divider counter; a clear always wins over a tick.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= 8'h00;
    end else if (clear) begin
      div_count <= 8'h00;
    end else if (tick_in) begin
      div_count <= at_last ? 8'h00 : div_count + 8'h01;
    end
  end

endmodule

/* gp_timer_sixteen_bit.sv */
// Sixteen-bit timer/counter with gating, prescaler and an AXI4-Lite register slave.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module gp_timer_sixteen_bit (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_clock_gate_pin,
  input  wire logic        cpu_idle,
  input  wire logic        cpu_sleep,
  output logic             timer_request
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] timer_control_reg;
  logic [15:0] count_value_reg;
  logic [15:0] period_value_reg;
  logic [1:0]  event_flags;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        pin_meta;
  logic        pin_sync;
  logic        pin_prev;
  logic        edge_pending;
  logic [1:0]  cycle_count;
  logic        run_prev;
  logic        div_tick;

  // Merges a bus write into a sixteen-bit register under byte strobes.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  wire timer_run_enable     = timer_control_reg[gp_timer_pkg::RUN_BIT];
  wire idle_stop_select     = timer_control_reg[gp_timer_pkg::IDLE_BIT];
  wire gated_accum_enable   = timer_control_reg[gp_timer_pkg::GATE_BIT];
  wire clock_source_select  = timer_control_reg[gp_timer_pkg::SRC_BIT];
  wire ext_sync_select      = timer_control_reg[gp_timer_pkg::SYNC_BIT];
  wire [1:0] input_divide_select = timer_control_reg[gp_timer_pkg::DIV_LSB +: 2];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire do_write   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ctrl    = do_write && (aw_addr == gp_timer_pkg::CTRL_OFFSET);
  wire wr_count   = do_write && (aw_addr == gp_timer_pkg::COUNT_OFFSET);
  wire wr_period  = do_write && (aw_addr == gp_timer_pkg::PERIOD_OFFSET);
  wire wr_status  = do_write && (aw_addr == gp_timer_pkg::STATUS_OFFSET);
  wire wr_mapped  = wr_ctrl || wr_count || wr_period || wr_status;
  wire rd_take    = s_axi_arvalid && s_axi_arready;
  wire rd_mapped  = (s_axi_araddr[1:0] == 2'h0);
  wire [15:0] rd_value = (s_axi_araddr == gp_timer_pkg::CTRL_OFFSET)   ? timer_control_reg :
                         (s_axi_araddr == gp_timer_pkg::COUNT_OFFSET)  ? count_value_reg :
                         (s_axi_araddr == gp_timer_pkg::PERIOD_OFFSET) ? period_value_reg :
                         {14'h0000, event_flags};

  // ----------------------------------------
  // Tick generation
  // ----------------------------------------
  wire cycle_tick  = (cycle_count == gp_timer_pkg::CYCLE_DIV_LAST);
  wire ext_rise    = pin_sync && !pin_prev;
  wire gate_fall   = timer_run_enable && gated_accum_enable && !clock_source_select &&
                     pin_prev && !pin_sync;
  wire async_mode  = clock_source_select && !ext_sync_select;
  wire idle_hold   = cpu_idle && idle_stop_select;
  wire sleep_hold  = cpu_sleep && !async_mode;
  wire run_ok      = timer_run_enable && !idle_hold && !sleep_hold;
  // Synchronous mode counts a pending pin edge on the next instruction cycle.
  wire sync_tick   = cycle_tick && (edge_pending || ext_rise);
  wire raw_tick    = !clock_source_select ?
                     (cycle_tick && (!gated_accum_enable || pin_sync)) :
                     (ext_sync_select ? sync_tick : ext_rise);
  wire pre_clear   = wr_count || (run_prev && !timer_run_enable);
  wire at_period   = (count_value_reg == period_value_reg);
  wire match_event = div_tick && at_period;
  wire [1:0] flag_set = {gate_fall, match_event};
  wire [1:0] flag_clr = wr_status ? (s_axi_wstrb_q0() & w_data[1:0]) : 2'h0;

  // Byte lane zero of the held write strobes, spread over both flag bits.
  function automatic logic [1:0] s_axi_wstrb_q0();
    s_axi_wstrb_q0 = {2{w_strb[0]}};
  endfunction

  input_prescaler u_prescaler (
    .clk                 (clk),
    .rst_n               (rst_n),
    .clear               (pre_clear),
    .tick_in             (raw_tick && run_ok),
    .input_divide_select (input_divide_select),
    .tick_out            (div_tick)
  );

  // Pin synchroniser and edge history.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= ext_clock_gate_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Instruction cycle divider, pending pin edge and run history.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_count  <= 2'h0;
      edge_pending <= 1'b0;
      run_prev     <= 1'b0;
    end else begin
      cycle_count  <= cycle_count + 2'h1;
      edge_pending <= cycle_tick ? 1'b0 : (edge_pending || ext_rise);
      run_prev     <= timer_run_enable;
    end
  end

  // Count register; a software write beats the hardware step.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value_reg <= gp_timer_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count_value_reg <= merge16(count_value_reg, w_data, w_strb);
    end else if (div_tick) begin
      count_value_reg <= at_period ? 16'h0000 : count_value_reg + 16'h0001;
    end
  end

  // Control, period and sticky event flags; a set wins over a clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_reg <= gp_timer_pkg::CTRL_RESET;
      period_value_reg  <= gp_timer_pkg::PERIOD_RESET;
      event_flags       <= 2'h0;
      timer_request     <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        timer_control_reg <= merge16(timer_control_reg, w_data, w_strb) & gp_timer_pkg::CTRL_MASK;
      end
      if (wr_period) begin
        period_value_reg <= merge16(period_value_reg, w_data, w_strb);
      end
      event_flags   <= (event_flags & ~flag_clr) | flag_set;
      timer_request <= |((event_flags & ~flag_clr) | flag_set);
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Write address and data are held independently; the response follows both.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= gp_timer_pkg::RESP_OKAY;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? gp_timer_pkg::RESP_OKAY : gp_timer_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= gp_timer_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mapped ? {16'h0000, rd_value} : 32'h0000_0000;
      s_axi_rresp   <= rd_mapped ? gp_timer_pkg::RESP_OKAY : gp_timer_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // A prescaled tick at the period brings the count back to zero.
  a_count_wraps_zero: assert property (div_tick && at_period && !wr_count |=>
    count_value_reg == 16'h0000)
    else $error("count did not wrap at period");
  // Idle with idle stop set freezes the count unless software loads it.
  a_idle_halts_count: assert property (idle_hold && !wr_count |=>
    $stable(count_value_reg))
    else $error("count moved during idle stop");
  // The asynchronous counter obeys idle stop as well.
  a_async_idle_stop: assert property (async_mode && idle_hold |-> !div_tick)
    else $error("async counter ticked in idle");
  // A low gate blocks the instruction ticks in gated mode.
  a_gate_low_holds: assert property (!clock_source_select && gated_accum_enable &&
    !pin_sync |-> !raw_tick)
    else $error("gated count advanced with gate low");
  // Dropping run enable clears the prescaler in the same cycle.
  a_run_clear_prescale: assert property ($fell(timer_run_enable) |-> pre_clear)
    else $error("prescaler not cleared on run disable");
  // Any prescaler clear leaves the divider counter at zero.
  a_prescale_cleared: assert property (pre_clear |=> u_prescaler.div_count == 8'h00)
    else $error("prescaler not cleared");
  // A stopped timer feeds no ticks into the prescaler.
  a_off_no_tick: assert property (!timer_run_enable |-> !div_tick)
    else $error("prescaler ticked while disabled");
  // A control write never disturbs the count.
  a_ctrl_keeps_count: assert property (wr_ctrl && !div_tick |=>
    $stable(count_value_reg))
    else $error("control write changed count");
  // A match sets the sticky flag and the request at the same edge.
  a_match_sets_flag: assert property (match_event |=>
    event_flags[gp_timer_pkg::MATCH_BIT] && timer_request)
    else $error("match flag or request missing");
  // Clearing both flags with no new event drops the request.
  a_clear_releases: assert property (flag_clr == 2'h3 && flag_set == 2'h0 |=>
    !timer_request)
    else $error("request stayed after flag clear");
  // The end of a gate window raises its own flag.
  a_gate_fall_flag: assert property (gate_fall |=> event_flags[gp_timer_pkg::GFALL_BIT])
    else $error("gate fall flag missing");
  // Sleep stops every mode except the asynchronous pin counter.
  a_sleep_sync_halt: assert property (cpu_sleep && !async_mode |-> !div_tick)
    else $error("counted in sleep when not async");
  // The asynchronous counter steps only on a pin rising edge.
  a_async_edge_only: assert property (async_mode && !ext_rise |-> !div_tick)
    else $error("async counter stepped without pin edge");
  // The synchronous counter steps only on an instruction cycle boundary.
  a_sync_on_cycle: assert property (clock_source_select && ext_sync_select |->
    (!div_tick || cycle_tick))
    else $error("sync counter stepped off the cycle");
  // A finished write raises its response in the next cycle.
  a_write_resp_once: assert property (do_write |=> s_axi_bvalid ##1 !do_write)
    else $error("write response not raised");
  // A taken read address is answered in the next cycle.
  a_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not raised");

  c_period_match: cover property (match_event);
  c_gate_fall:    cover property (gate_fall);
  c_async_sleep:  cover property (cpu_sleep && async_mode && div_tick);
  c_flag_cleared: cover property (wr_status && event_flags[0] ##1 !event_flags[0]);
  c_sync_count:   cover property (clock_source_select && ext_sync_select && div_tick);

endmodule

/* ext_pin_source.sv */
// Behavioural source for the external clock or gate pin.
`timescale 1ns/1ps
module ext_pin_source (
  input  wire logic clk,
  output logic      pin
);
  // The pin rests low outside every frame.
  initial pin = 1'b0;

  // ----------------------------------------
  // Frames
  // ----------------------------------------
  // Clock pulses kept slower than the synchroniser needs.
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge clk);
      pin <= 1'b1;
      repeat (half) @(posedge clk);
      pin <= 1'b0;
    end
  endtask

  // One gate window held high for a number of clocks.
  task automatic gate(input int len);
    pin <= 1'b1;
    repeat (len) @(posedge clk);
    pin <= 1'b0;
  endtask
endmodule

/* gp_timer_sixteen_bit_tb.sv */
// Self-checking bench for the sixteen-bit timer.
`timescale 1ns/1ps
module gp_timer_sixteen_bit_tb;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, idle, sleep;
  logic        awready, wready, bvalid, arready, rvalid, req, pin;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] v;
  int          fails, num_checks, cyc, t0, seed, n, p;
  int          divs[4] = '{1, 8, 64, 256};

  gp_timer_sixteen_bit dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_clock_gate_pin(pin), .cpu_idle(idle),
    .cpu_sleep(sleep), .timer_request(req));
  ext_pin_source src_u (.clk(clk), .pin(pin));

  // Clock and a cycle watchdog that cuts a hang short.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 32'h7fffffff;
  endfunction

  // Bus write: both channels offered together, each released when taken.
  task automatic axw(input logic [3:0] a, input logic [15:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // Bus read; the answer lands in v and r.
  task automatic axr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata[15:0];
    r = rresp;
    rready <= 1'b0;
  endtask

  // Compare with the model, modulo m, allowing one tick of divider phase either way when t is nonzero.
  task automatic chk(input logic [15:0] got, input int e, input int m, input int t);
    num_checks++;
    if (got !== 16'(e % m) && (t == 0 || (got !== 16'((e + 1) % m)
        && got !== 16'((e + m - 1) % m)))) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %0d", $time, got, e % m);
    end
  endtask

  // Run with control c for n cycles, stop, then read the count.
  task automatic run(input logic [15:0] c, input int n);
    axw(gp_timer_pkg::CTRL_OFFSET, c);
    t0 = cyc;
    repeat (n) @(posedge clk);
    axw(gp_timer_pkg::CTRL_OFFSET, 16'h0000);
    t0 = cyc - t0;
    axr(gp_timer_pkg::COUNT_OFFSET);
  endtask

  // Count n pin pulses under control c, with sleep s and idle i.
  task automatic ext(input logic [15:0] c, input logic s, input logic i);
    axw(gp_timer_pkg::COUNT_OFFSET, 16'h0000);
    axw(gp_timer_pkg::CTRL_OFFSET, c);
    sleep <= s;
    idle <= i;
    src_u.pulses(n, 8);
    sleep <= 1'b0;
    idle <= 1'b0;
    axw(gp_timer_pkg::CTRL_OFFSET, 16'h0000);
    axr(gp_timer_pkg::COUNT_OFFSET);
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, idle, sleep} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    seed = 15654;
    {fails, num_checks, cyc} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 16; a += 4) begin
      axr(4'(a));
      chk(v, 0, 65536, 0);
      chk(rdata[31:16], 0, 65536, 0);
      chk({14'h0, r}, gp_timer_pkg::RESP_OKAY, 65536, 0);
    end
    axr(4'h2);
    chk({14'h0, r}, gp_timer_pkg::RESP_SLVERR, 65536, 0);
    axw(4'h6, 16'hffff);
    chk({14'h0, r}, gp_timer_pkg::RESP_SLVERR, 65536, 0);
    $display("Reset test done");
    for (int k = 0; k < 4; k++) begin
      axw(gp_timer_pkg::PERIOD_OFFSET, 16'hffff);
      axw(gp_timer_pkg::COUNT_OFFSET, 16'h0000);
      run(16'h8000 | 16'(k << 4), 8 * divs[k] + rnd() % 64);
      chk(v, t0 / (4 * divs[k]), 65536, 1);
    end
    $display("Prescaler test done");
    p = 3 + rnd() % 5;
    axw(gp_timer_pkg::PERIOD_OFFSET, 16'(p));
    axw(gp_timer_pkg::COUNT_OFFSET, 16'h0000);
    axw(gp_timer_pkg::STATUS_OFFSET, 16'h0003);
    run(16'h8000, 200);
    chk(v, t0 / 4, p + 1, 1);
    axr(gp_timer_pkg::STATUS_OFFSET);
    chk(v, 1, 65536, 0);
    chk({15'h0, req}, 1, 65536, 0);
    axw(gp_timer_pkg::STATUS_OFFSET, 16'h0001);
    axr(gp_timer_pkg::STATUS_OFFSET);
    chk(v, 0, 65536, 0);
    chk({15'h0, req}, 0, 65536, 0);
    axw(gp_timer_pkg::COUNT_OFFSET, 16'h1234);
    chk({14'h0, r}, gp_timer_pkg::RESP_OKAY, 65536, 0);
    axw(gp_timer_pkg::CTRL_OFFSET, 16'h0076);
    axr(gp_timer_pkg::COUNT_OFFSET);
    chk(v, 'h1234, 65536, 0);
    $display("Period match test done");
    axw(gp_timer_pkg::PERIOD_OFFSET, 16'hffff);
    axw(gp_timer_pkg::COUNT_OFFSET, 16'h0000);
    idle <= 1'b1;
    run(16'ha000, 100);
    chk(v, 0, 65536, 0);
    run(16'h8000, 100);
    chk(v, t0 / 4, 65536, 1);
    idle <= 1'b0;
    $display("Idle test done");
    n = 3 + rnd() % 10;
    ext(16'h8002, 1'b1, 1'b0);
    chk(v, n, 65536, 0);
    ext(16'ha002, 1'b0, 1'b1);
    chk(v, 0, 65536, 0);
    ext(16'h8006, 1'b0, 1'b0);
    chk(v, n, 65536, 0);
    ext(16'h8006, 1'b1, 1'b0);
    chk(v, 0, 65536, 0);
    $display("Pin counter test done");
    axw(gp_timer_pkg::COUNT_OFFSET, 16'h0000);
    axw(gp_timer_pkg::CTRL_OFFSET, 16'h8040);
    src_u.gate(40);
    repeat (8) @(posedge clk);
    axw(gp_timer_pkg::CTRL_OFFSET, 16'h0000);
    axr(gp_timer_pkg::COUNT_OFFSET);
    chk(v, 10, 65536, 1);
    axr(gp_timer_pkg::STATUS_OFFSET);
    chk(v, 2, 65536, 0);
    chk({15'h0, req}, 1, 65536, 0);
    axw(gp_timer_pkg::STATUS_OFFSET, 16'h0003);
    axr(gp_timer_pkg::STATUS_OFFSET);
    chk(v, 0, 65536, 0);
    $display("Gated test done");
    end_sim();
  end
endmodule
